// ---- core/dual_octal_edge_register.sv ----
// Dual 8-bit edge-triggered storage with three-state outputs, on the system clock
`timescale 1ns/10ps
// How it works
// - Two sections of eight flip-flops, each bit with its own three-state driver.
// - Each section has its own clock and enable and never disturbs the other.
// - A rising section clock, with power on and section_load_ready_o high, loads that section's eight data inputs.
// - Only the rising edge of a section clock loads data.
// - Without a rising edge the stored bits change only when a buffered word is accepted or loss of supply or reset_i clears them.
// - Enable low drives the stored bits onto the section's outputs.
// - Enable high releases all eight outputs of the section.
// - Enable gates only drivers; loads while released still happen.
// - While supply ramps up or down, all outputs stay released.
// - Power-up clears all stored bits to low.
// - Hold variant keeps each undriven data input at its last level.
module dual_octal_edge_register #(
	parameter bit BUS_HOLD = 1'b1
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic supply_ok_i,
	input wire logic [octal_reg_pkg::SECTION_COUNT-1:0] section_clock_i,
	input wire logic [octal_reg_pkg::SECTION_COUNT-1:0] section_output_enable_low_i,
	input wire logic [octal_reg_pkg::SECTION_COUNT-1:0][7:0] section_bit_in_i,
	input wire logic [octal_reg_pkg::SECTION_COUNT-1:0][7:0] section_bit_in_driven_i,
	output logic [octal_reg_pkg::SECTION_COUNT-1:0] section_load_ready_o,
	input wire logic [octal_reg_pkg::SECTION_COUNT-1:0] section_accept_i,
	output logic [octal_reg_pkg::SECTION_COUNT-1:0][7:0] section_bit_out_o,
	output logic [octal_reg_pkg::SECTION_COUNT-1:0][7:0] section_bit_out_oe_o
);
	import octal_reg_pkg::*;

	// ==========================================================
	// Declarations
	logic supply_meta_reg;
	logic supply_meta_next;
	logic supply_sync_reg;
	logic supply_sync_next;
	logic [SECTION_COUNT-1:0] clk_meta_reg;
	logic [SECTION_COUNT-1:0] clk_meta_next;
	logic [SECTION_COUNT-1:0] clk_sync_reg;
	logic [SECTION_COUNT-1:0] clk_sync_next;
	logic [SECTION_COUNT-1:0] clk_prev_reg;
	logic [SECTION_COUNT-1:0] clk_prev_next;
	logic [SECTION_COUNT-1:0] en_meta_reg;
	logic [SECTION_COUNT-1:0] en_meta_next;
	logic [SECTION_COUNT-1:0] en_sync_reg;
	logic [SECTION_COUNT-1:0] en_sync_next;
	logic [SECTION_COUNT-1:0][7:0] kept_level;
	logic [SECTION_COUNT-1:0][7:0] data_meta_reg;
	logic [SECTION_COUNT-1:0][7:0] data_meta_next;
	logic [SECTION_COUNT-1:0][7:0] data_sync_reg;
	logic [SECTION_COUNT-1:0][7:0] data_sync_next;
	logic [SECTION_COUNT-1:0][7:0] driven_meta_reg;
	logic [SECTION_COUNT-1:0][7:0] driven_meta_next;
	logic [SECTION_COUNT-1:0][7:0] driven_sync_reg;
	logic [SECTION_COUNT-1:0][7:0] driven_sync_next;
	logic [SECTION_COUNT-1:0][7:0] store_reg;
	logic [SECTION_COUNT-1:0][7:0] store_next;
	logic [SECTION_COUNT-1:0][7:0] oe_reg;
	logic [SECTION_COUNT-1:0][7:0] oe_next;
	logic [SECTION_COUNT-1:0][7:0] buf_data;
	logic [SECTION_COUNT-1:0] rise;
	logic [SECTION_COUNT-1:0] buf_valid;
	logic [SECTION_COUNT-1:0] buf_ready;
	logic [SECTION_COUNT-1:0] pop;
	power_state_e pwr_state_reg;
	power_state_e pwr_state_next;
	logic [RAMP_CNT_W-1:0] ramp_cnt_reg;
	logic [RAMP_CNT_W-1:0] ramp_cnt_next;
	logic power_on;

	// ==========================================================
	// Pin synchronisers, two flops before any logic
	always_comb begin
		supply_meta_next = supply_ok_i;
		supply_sync_next = supply_meta_reg;
		clk_meta_next = section_clock_i;
		clk_sync_next = clk_meta_reg;
		clk_prev_next = clk_sync_reg;
		en_meta_next = section_output_enable_low_i;
		en_sync_next = en_meta_reg;
		data_meta_next = section_bit_in_i;
		data_sync_next = data_meta_reg;
		driven_meta_next = section_bit_in_driven_i;
		driven_sync_next = driven_meta_reg;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			supply_meta_reg <= SYNC_RESET;
			supply_sync_reg <= SYNC_RESET;
			clk_meta_reg <= '0;
			clk_sync_reg <= '0;
			clk_prev_reg <= '0;
			en_meta_reg <= '1;
			en_sync_reg <= '1;
			data_meta_reg <= '0;
			data_sync_reg <= '0;
			driven_meta_reg <= '1;
			driven_sync_reg <= '1;
		end else begin
			supply_meta_reg <= supply_meta_next;
			supply_sync_reg <= supply_sync_next;
			clk_meta_reg <= clk_meta_next;
			clk_sync_reg <= clk_sync_next;
			clk_prev_reg <= clk_prev_next;
			en_meta_reg <= en_meta_next;
			en_sync_reg <= en_sync_next;
			data_meta_reg <= data_meta_next;
			data_sync_reg <= data_sync_next;
			driven_meta_reg <= driven_meta_next;
			driven_sync_reg <= driven_sync_next;
		end
	end

	// Low-to-high only; falling edges are ignored
	assign rise = clk_sync_reg & ~clk_prev_reg;

	// ==========================================================
	// Supply sequencing
	always_comb begin
		pwr_state_next = pwr_state_reg;
		ramp_cnt_next = ramp_cnt_reg;
		case (pwr_state_reg)
			PWR_OFF: begin
				ramp_cnt_next = RAMP_CNT_RESET;
				if (supply_sync_reg) begin
					pwr_state_next = PWR_RAMP;
				end
			end
			PWR_RAMP: begin
				if (!supply_sync_reg) begin
					pwr_state_next = PWR_OFF;
				end else if (ramp_cnt_reg == RAMP_CNT_W'(RAMP_CYCLES - 1)) begin
					pwr_state_next = PWR_ON;
				end else begin
					ramp_cnt_next = ramp_cnt_reg + 4'h1;
				end
			end
			PWR_ON: begin
				if (!supply_sync_reg) begin
					pwr_state_next = PWR_OFF;
				end
			end
			default: begin
				pwr_state_next = PWR_OFF;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pwr_state_reg <= PWR_OFF;
			ramp_cnt_reg <= RAMP_CNT_RESET;
		end else begin
			pwr_state_reg <= pwr_state_next;
			ramp_cnt_reg <= ramp_cnt_next;
		end
	end

	assign power_on = (pwr_state_reg == PWR_ON);

	// ==========================================================
	// Per-section keeper and capture buffer
	for (genvar s = 0; s < SECTION_COUNT; s++) begin : g_sec
		bus_hold_keeper #(
			.WIDTH(SECTION_WIDTH),
			.HOLD_ENABLE(BUS_HOLD)
		) u_keep (
			.sys_clk_i(sys_clk_i),
			.reset_i(reset_i),
			.pin_i(data_sync_reg[s]),
			.driven_i(driven_sync_reg[s]),
			.level_o(kept_level[s])
		);

		two_entry_buffer #(
			.WIDTH(SECTION_WIDTH)
		) u_buf (
			.sys_clk_i(sys_clk_i),
			.reset_i(reset_i),
			.flush_i(!power_on),
			.in_valid_i(rise[s] & power_on),
			.in_ready_o(buf_ready[s]),
			.in_data_i(kept_level[s]),
			.out_valid_o(buf_valid[s]),
			.out_ready_i(section_accept_i[s]),
			.out_data_o(buf_data[s])
		);
	end

	assign section_load_ready_o = buf_ready;
	assign pop = buf_valid & section_accept_i & {SECTION_COUNT{power_on}};

	// ==========================================================
	// Storage and output drivers, each section on its own controls
	always_comb begin
		store_next = store_reg;
		oe_next = oe_reg;
		for (int i = 0; i < SECTION_COUNT; i++) begin
			if (!power_on) begin
				store_next[i] = STORE_RESET;
			end else if (pop[i]) begin
				store_next[i] = buf_data[i];
			end
			if (power_on && !en_sync_reg[i]) begin
				oe_next[i] = OE_ALL_ON;
			end else begin
				oe_next[i] = OE_ALL_OFF;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			store_reg <= '0;
			oe_reg <= '0;
		end else begin
			store_reg <= store_next;
			oe_reg <= oe_next;
		end
	end

	// Every bit has its own flop and its own driver enable
	assign section_bit_out_o = store_reg;
	assign section_bit_out_oe_o = oe_reg;

	// ==========================================================
	// Checks
	sequence s_rise(int i);
		clk_sync_reg[i] && !clk_prev_reg[i];
	endsequence

	sequence s_push_ok(int i);
		s_rise(i) ##0 power_on && buf_ready[i];
	endsequence

	property p_hold_without_pop(int i);
		@(posedge sys_clk_i) disable iff (reset_i)
		(power_on && !pop[i]) |=> $stable(store_reg[i]);
	endproperty
	a_hold0: assert property (p_hold_without_pop(0)) else $error("section 0 changed");
	a_hold1: assert property (p_hold_without_pop(1)) else $error("section 1 changed");

	property p_edge_loads(int i);
		@(posedge sys_clk_i) disable iff (reset_i)
		(s_push_ok(i) ##0 !buf_valid[i] ##1 power_on && section_accept_i[i])
		|=> (store_reg[i] == $past(kept_level[i], 2));
	endproperty
	a_edge_loads: assert property (p_edge_loads(0)) else $error("edge did not load");
	a_edge_loads1: assert property (p_edge_loads(1)) else $error("edge 1 did not load");

	property p_fall_ignored(int i);
		@(posedge sys_clk_i) disable iff (reset_i)
		(!clk_sync_reg[i] && clk_prev_reg[i] && !buf_valid[i]) |=> !buf_valid[i];
	endproperty
	a_fall_ignored: assert property (p_fall_ignored(0)) else $error("falling edge loaded");

	property p_enable_drives(int i);
		@(posedge sys_clk_i) disable iff (reset_i)
		(power_on && !en_sync_reg[i] && $past(power_on)) |=> (oe_reg[i] == OE_ALL_ON);
	endproperty
	a_enable_drives: assert property (p_enable_drives(1)) else $error("enabled not driven");

	property p_disable_releases(int i);
		@(posedge sys_clk_i) disable iff (reset_i)
		en_sync_reg[i] |=> (oe_reg[i] == OE_ALL_OFF);
	endproperty
	a_disable_releases: assert property (p_disable_releases(0)) else $error("driving while off");
	a_disable_releases1: assert property (p_disable_releases(1)) else $error("1 driving while off");

	property p_load_while_off(int i);
		@(posedge sys_clk_i) disable iff (reset_i)
		(pop[i] && en_sync_reg[i]) |=> (store_reg[i] == $past(buf_data[i]));
	endproperty
	a_load_while_off: assert property (p_load_while_off(1)) else $error("load lost");
	a_load_while_off0: assert property (p_load_while_off(0)) else $error("load 0 lost");

	property p_supply_release;
		@(posedge sys_clk_i) disable iff (reset_i)
		!power_on |=> (oe_reg == '0) && (store_reg == '0);
	endproperty
	a_supply_release: assert property (p_supply_release) else $error("active without supply");

	property p_ramp_length;
		@(posedge sys_clk_i) disable iff (reset_i)
		(pwr_state_reg == PWR_OFF && supply_sync_reg) ##1 supply_sync_reg [*8]
		|-> !power_on;
	endproperty
	a_ramp_length: assert property (p_ramp_length) else $error("ramp too short");

	// Supply held through the whole ramp brings power_on up
	sequence s_ramp_held;
		supply_sync_reg [*8] ##1 supply_sync_reg [*2];
	endsequence

	property p_ramp_done;
		@(posedge sys_clk_i) disable iff (reset_i)
		(pwr_state_reg == PWR_OFF && supply_sync_reg) ##1 s_ramp_held |=> power_on;
	endproperty
	a_ramp_done: assert property (p_ramp_done) else $error("ramp never ended");

	property p_reset_clears;
		@(posedge sys_clk_i)
		reset_i |=> (store_reg == '0) && (oe_reg == '0);
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset left state");
endmodule

// ---- core/octal_reg_pkg.sv ----
// Shared constants and types for the dual octal edge register
package octal_reg_pkg;
	// ==========================================================
	// Geometry
	localparam int SECTION_COUNT = 2;
	localparam int SECTION_WIDTH = 8;
	localparam int BUF_DEPTH = 2;
	// ==========================================================
	// Reset values and output-enable patterns
	localparam logic [7:0] STORE_RESET = 8'h00;
	localparam logic [7:0] OE_ALL_ON = 8'hFF;
	localparam logic [7:0] OE_ALL_OFF = 8'h00;
	localparam logic SYNC_RESET = 1'h0;
	localparam logic ENABLE_LOW_RESET = 1'h1;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int RAMP_TIME_NS = 1000;
	localparam int RAMP_CYCLES = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAMP_CNT_W = 4;
	localparam logic [3:0] RAMP_CNT_RESET = 4'h0;
	// ==========================================================
	// Supply states
	typedef enum logic [1:0] {
		PWR_OFF = 2'b00,
		PWR_RAMP = 2'b01,
		PWR_ON = 2'b10
	} power_state_e;
endpackage

// ---- core/bus_hold_keeper.sv ----
// Bus-hold keeper that remembers the last driven level of each data pin
`timescale 1ns/10ps
module bus_hold_keeper #(
	parameter int WIDTH = 8,
	parameter bit HOLD_ENABLE = 1'b1
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] pin_i,
	input wire logic [WIDTH-1:0] driven_i,
	output logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] held_reg;
	logic [WIDTH-1:0] held_next;

	// Keep the last driven level per bit
	always_comb begin
		held_next = (driven_i & pin_i) | (~driven_i & held_reg);
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			held_reg <= '0;
		end else begin
			held_reg <= held_next;
		end
	end

	// Undriven bits read the held level in the hold variant
	assign level_o = HOLD_ENABLE ? held_next : pin_i;

	// ==========================================================
	// Checks
	property p_keep_level;
		@(posedge sys_clk_i) disable iff (reset_i)
		(HOLD_ENABLE && driven_i == '0) |-> (level_o == held_reg);
	endproperty
	a_keep_level: assert property (p_keep_level) else $error("undriven pin lost its level");
endmodule

// ---- core/two_entry_buffer.sv ----
// Two-entry valid/ready buffer between edge capture and the storage register
`timescale 1ns/10ps
module two_entry_buffer #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	logic [WIDTH-1:0] slot0_reg;
	logic [WIDTH-1:0] slot0_next;
	logic [WIDTH-1:0] slot1_reg;
	logic [WIDTH-1:0] slot1_next;
	logic [1:0] count_reg;
	logic [1:0] count_next;
	logic push;
	logic pop;

	// Handshakes, honest full and empty
	assign in_ready_o = (count_reg != 2'h2);
	assign out_valid_o = (count_reg != 2'h0);
	assign out_data_o = slot0_reg;
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// Slot 0 is the head; slot 1 the second word
	always_comb begin
		slot0_next = slot0_reg;
		slot1_next = slot1_reg;
		count_next = count_reg;
		if (pop) begin
			slot0_next = slot1_reg;
		end
		if (push) begin
			if (count_reg == 2'h0 || (count_reg == 2'h1 && pop)) begin
				slot0_next = in_data_i;
			end else begin
				slot1_next = in_data_i;
			end
		end
		count_next = count_reg + {1'b0, push} - {1'b0, pop};
		if (flush_i) begin
			count_next = 2'h0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			slot0_reg <= '0;
			slot1_reg <= '0;
			count_reg <= 2'h0;
		end else begin
			slot0_reg <= slot0_next;
			slot1_reg <= slot1_next;
			count_reg <= count_next;
		end
	end

	// ==========================================================
	// Checks
	property p_no_overfill;
		@(posedge sys_clk_i) disable iff (reset_i)
		(count_reg == 2'h2) |-> !in_ready_o;
	endproperty
	a_no_overfill: assert property (p_no_overfill) else $error("full buffer accepted a word");
endmodule

// ---- dv/bus_driver_model.sv ----
// Upstream bus-driving logic model feeding clocks, data and enables
`timescale 1ns/10ps
module bus_driver_model (
	input wire logic sys_clk_i,
	output logic [1:0] section_clock_o,
	output logic [1:0] section_output_enable_low_o,
	output logic [1:0][7:0] section_bit_o,
	output logic [1:0][7:0] section_bit_driven_o
);
	// ==========================================
	// Idle state
	// Clocks low, outputs released, data driven low
	initial begin
		section_clock_o = 2'h0;
		section_output_enable_low_o = 2'h3;
		section_bit_o = 16'h0000;
		section_bit_driven_o = 16'hffff;
	end
	// Wait whole cycles, then step just past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	// Drive a word, then one clock pulse; setup, high and low 3 cycles each
	task automatic load(input int s, input logic [7:0] d);
		section_bit_o[s] = d;
		section_bit_driven_o[s] = 8'hff;
		cyc(3);
		section_clock_o[s] = 1'b1;
		cyc(3);
		section_clock_o[s] = 1'b0;
		cyc(3);
	endtask
	// Stop driving the data pins; the wire shows the inverse level
	task automatic release_data(input int s);
		section_bit_driven_o[s] = 8'h00;
		section_bit_o[s] = ~section_bit_o[s];
		cyc(3);
	endtask
	// Change data with no clock edge
	task automatic set_data(input int s, input logic [7:0] d);
		section_bit_o[s] = d;
		section_bit_driven_o[s] = 8'hff;
		cyc(3);
	endtask
	// Move one section clock to a level
	task automatic set_clock(input int s, input logic v);
		section_clock_o[s] = v;
		cyc(3);
	endtask
	// Low to read, high to release the bus
	task automatic set_enable(input int s, input logic v);
		section_output_enable_low_o[s] = v;
		cyc(4);
	endtask
endmodule

// ---- dv/dual_octal_edge_register_tb_top.sv ----
// Self-checking bench for the dual octal edge register
`timescale 1ns/10ps
module dual_octal_edge_register_tb_top;
	import octal_reg_pkg::*;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic supply_ok_i = 1'b1;
	logic [1:0] accept = 2'h3;
	logic [1:0] clk_pin;
	logic [1:0] oe_low;
	logic [1:0] ready;
	logic [1:0][7:0] bit_in;
	logic [1:0][7:0] driven;
	logic [1:0][7:0] q;
	logic [1:0][7:0] oe;
	int n_mismatch = 0;
	int total_checks = 0;
	int cycles = 0;
	// ==========================================
	// Clock and instances
	always #50 sys_clk_i = ~sys_clk_i;
	bus_driver_model bus_driver_model_inst (
		.sys_clk_i(sys_clk_i),
		.section_clock_o(clk_pin),
		.section_output_enable_low_o(oe_low),
		.section_bit_o(bit_in),
		.section_bit_driven_o(driven)
	);
	dual_octal_edge_register dual_octal_edge_register_inst (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.supply_ok_i(supply_ok_i),
		.section_clock_i(clk_pin),
		.section_output_enable_low_i(oe_low),
		.section_bit_in_i(bit_in),
		.section_bit_in_driven_i(driven),
		.section_load_ready_o(ready),
		.section_accept_i(accept),
		.section_bit_out_o(q),
		.section_bit_out_oe_o(oe)
	);
	// ==========================================
	// Compare and report
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	// Hang guard
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles > 3000) begin
			n_mismatch++;
			finish_test();
		end
	end
	// ==========================================
	// Scenarios
	task automatic t_power_up();
		cyc(8);
		check8(q[0], 8'h00);
		check8(oe[1], 8'h00);
		check1(ready[0], 1'b1);
		reset_i = 1'b0;
		bus_driver_model_inst.set_enable(0, 1'b0);
		bus_driver_model_inst.set_enable(1, 1'b0);
		check8(oe[0], 8'h00);
		cyc(20);
		check8(oe[0], 8'hff);
		check8(oe[1], 8'hff);
		check8(q[1], 8'h00);
	endtask
	task automatic t_load();
		bus_driver_model_inst.load(0, 8'ha5);
		bus_driver_model_inst.load(1, 8'h3c);
		check8(q[0], 8'ha5);
		check8(q[1], 8'h3c);
		bus_driver_model_inst.load(0, 8'h5a);
		check8(q[0], 8'h5a);
		check8(q[1], 8'h3c);
	endtask
	task automatic t_no_edge();
		bus_driver_model_inst.set_data(0, 8'hff);
		cyc(4);
		check8(q[0], 8'h5a);
		bus_driver_model_inst.set_clock(0, 1'b1);
		bus_driver_model_inst.set_data(0, 8'h0f);
		bus_driver_model_inst.set_clock(0, 1'b0);
		cyc(4);
		check8(q[0], 8'hff);
	endtask
	task automatic t_enable();
		bus_driver_model_inst.set_enable(0, 1'b1);
		check8(oe[0], 8'h00);
		check8(oe[1], 8'hff);
		bus_driver_model_inst.load(0, 8'h81);
		bus_driver_model_inst.set_enable(0, 1'b0);
		check8(oe[0], 8'hff);
		check8(q[0], 8'h81);
	endtask
	task automatic t_bus_hold();
		bus_driver_model_inst.load(1, 8'hc3);
		bus_driver_model_inst.release_data(1);
		bus_driver_model_inst.set_clock(1, 1'b1);
		bus_driver_model_inst.set_clock(1, 1'b0);
		cyc(4);
		check8(q[1], 8'hc3);
	endtask
	// Two words fill the buffer, the third edge is dropped; one word per cycle drains
	task automatic t_buffer();
		accept[0] = 1'b0;
		bus_driver_model_inst.load(0, 8'h11);
		bus_driver_model_inst.load(0, 8'h22);
		check1(ready[0], 1'b0);
		bus_driver_model_inst.load(0, 8'h33);
		check8(q[0], 8'h81);
		accept[0] = 1'b1;
		cyc(1);
		check8(q[0], 8'h11);
		cyc(1);
		check8(q[0], 8'h22);
		check1(ready[0], 1'b1);
		cyc(4);
		check8(q[0], 8'h22);
	endtask
	task automatic t_supply();
		supply_ok_i = 1'b0;
		cyc(6);
		check8(oe[0], 8'h00);
		check8(oe[1], 8'h00);
		supply_ok_i = 1'b1;
		cyc(20);
		check8(q[0], 8'h00);
		check8(oe[1], 8'hff);
	endtask
	// Reset in mid-run clears loaded bits and releases both sections
	task automatic t_reset();
		bus_driver_model_inst.load(0, 8'h77);
		check8(q[0], 8'h77);
		reset_i = 1'b1;
		cyc(2);
		check8(q[0], 8'h00);
		check8(oe[0], 8'h00);
		check8(oe[1], 8'h00);
		check1(ready[0], 1'b1);
		reset_i = 1'b0;
		cyc(2);
		check8(oe[1], 8'h00);
		cyc(18);
		check8(oe[0], 8'hff);
		check8(q[0], 8'h00);
	endtask
	// Main sequence
	initial begin
		t_power_up();
		t_load();
		t_no_edge();
		t_enable();
		t_bus_hold();
		t_buffer();
		t_supply();
		t_reset();
		finish_test();
	end
endmodule
